// file: eep_pkg.sv
`default_nettype none
package eep_pkg;
    localparam int ARRAY_BYTES = 512;
    localparam int MEM_WORDS = 515;
    localparam logic [15:0] ARRAY_BASE = 16'h0800;
    localparam logic [15:0] NV_DIV_HIGH_ADDR = 16'hfe10;
    localparam logic [15:0] NV_DIV_LOW_ADDR = 16'hfe11;
    localparam logic [15:0] DIV_HIGH_ADDR = 16'hfe1a;
    localparam logic [15:0] DIV_LOW_ADDR = 16'hfe1b;
    localparam logic [15:0] NV_CONFIG_ADDR = 16'hfe1c;
    localparam logic [15:0] CONTROL_ADDR = 16'hfe1d;
    localparam logic [15:0] ARRAY_CFG_ADDR = 16'hfe1f;
    localparam logic [9:0] IDX_NV_CONFIG = 10'h200;
    localparam logic [9:0] IDX_NV_DIV_HIGH = 10'h201;
    localparam logic [9:0] IDX_NV_DIV_LOW = 10'h202;
    localparam logic [8:0] SECURE_LO = 9'h0f0;
    localparam logic [8:0] SECURE_HI = 9'h0ff;
    localparam int PROTECT_BIT = 4;
    localparam int LOCK_BIT = 7;
    localparam logic [7:0] DIV_HIGH_MASK = 8'h87;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] NV_CONFIG_FACTORY = 8'hf0;
    localparam int TIMEBASE_US = 35;
    localparam int CORE_CLK_MHZ = 100;
    localparam int TIMEBASE_CORE_CYCLES = TIMEBASE_US * CORE_CLK_MHZ;
    localparam int AUTO_TICKS = 8;

    typedef enum logic [1:0] {
        MODE_PROGRAM = 2'b00,
        MODE_BYTE_ERASE = 2'b01,
        MODE_BLOCK_ERASE = 2'b10,
        MODE_BULK_ERASE = 2'b11
    } eep_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PUMP = 2'b10
    } eep_state_e;

    typedef struct packed {
        logic spare;
        logic unimpl;
        logic array_power_down;
        eep_mode_e mode;
        logic latch_enable_bit;
        logic auto_end;
        logic pump_enable_bit;
    } eep_ctrl_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } eep_bus_req_s;

    typedef struct packed {
        eep_mode_e mode;
        logic [9:0] idx;
        logic [7:0] data;
    } eep_op_s;
endpackage
`default_nettype wire

// file: eep_array.sv
`timescale 1ns/1ps
`default_nettype none
module eep_array import eep_pkg::*; #(
    parameter int WORDS = MEM_WORDS
) (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic commit,
    input wire eep_op_s op,
    input wire logic [9:0] rd_idx,
    output logic [7:0] rd_byte,
    output logic [7:0] nv_config_byte,
    output logic [7:0] nv_divider_high,
    output logic [7:0] nv_divider_low
);
    // Nonvolatile cells: no reset, contents survive every MCU reset
    // Starting contents stand for the factory state of the cells
    logic [7:0] mem [WORDS] = '{
        IDX_NV_CONFIG: NV_CONFIG_FACTORY,
        default: ERASED_BYTE
    };

    always_ff @(posedge core_clk) begin
        if (ce && commit) begin
            unique case (op.mode)
                MODE_PROGRAM: mem[op.idx] <= mem[op.idx] & op.data;
                MODE_BYTE_ERASE: mem[op.idx] <= ERASED_BYTE;
                MODE_BLOCK_ERASE: begin
                    for (int i = 0; i < ARRAY_BYTES; i++) begin
                        if (9'(i) >> 7 == 9'(op.idx[8:7])) begin
                            mem[i] <= ERASED_BYTE;
                        end
                    end
                end
                MODE_BULK_ERASE: begin
                    for (int i = 0; i < ARRAY_BYTES; i++) begin
                        mem[i] <= ERASED_BYTE;
                    end
                end
            endcase
        end
    end

    assign rd_byte = mem[rd_idx];
    assign nv_config_byte = mem[IDX_NV_CONFIG];
    assign nv_divider_high = mem[IDX_NV_DIV_HIGH];
    assign nv_divider_low = mem[IDX_NV_DIV_LOW];
endmodule // eep_array
`default_nettype wire

// file: eep_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module eep_timebase import eep_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic crystal_ref_clock,
    input wire logic divider_clock_select,
    input wire logic [15:0] divider,
    output logic tick
);
    logic sync1, sync2, sync3;
    logic [15:0] count, next_count;
    logic next_tick, ref_edge;

    always_comb begin
        // Crystal edges are counted; bus clock counts every cycle
        ref_edge = divider_clock_select ? (sync2 & ~sync3) : 1'b1;
        next_count = count;
        next_tick = 1'b0;
        if (ref_edge) begin
            if (count + 16'h0001 >= divider) begin
                next_count = 16'h0000;
                next_tick = 1'b1;
            end else begin
                next_count = count + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            count <= 16'h0000;
            tick <= 1'b0;
        end else if (ce) begin
            sync1 <= crystal_ref_clock;
            sync2 <= sync1;
            sync3 <= sync2;
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule // eep_timebase
`default_nettype wire

// file: eep_ctrl.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl import eep_pkg::*; #(
    parameter int OP_TICKS = AUTO_TICKS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic crystal_ref_clock,
    input wire logic divider_clock_select,
    input wire eep_bus_req_s bus_req,
    output logic [7:0] rd_data,
    output logic pump_on,
    output logic array_power_down,
    output logic timebase_tick
);
    eep_ctrl_s ctrl, next_ctrl, wr_ctrl;
    logic [4:0] array_cfg, next_array_cfg;
    logic [7:0] div_high, next_div_high;
    logic [7:0] div_low, next_div_low;
    logic load_pending, next_load_pending;
    logic latch_valid, next_latch_valid;
    eep_op_s latch_op, next_latch_op, commit_op;
    eep_state_e state, next_state;
    logic [7:0] tick_count, next_tick_count;
    logic [7:0] next_rd_data;
    logic commit;
    logic [9:0] req_idx;
    logic req_mapped;
    logic [7:0] mem_byte, nv_cfg, nv_div_high, nv_div_low;

    function automatic logic in_array(input logic [15:0] a);
        return a >= ARRAY_BASE && a < ARRAY_BASE + 16'(ARRAY_BYTES);
    endfunction

    // Array and the three nonvolatile registers share one index space
    function automatic logic [9:0] nv_index(input logic [15:0] a);
        logic [15:0] off;
        off = a - ARRAY_BASE;
        if (in_array(a)) begin
            return off[9:0];
        end else if (a == NV_CONFIG_ADDR) begin
            return IDX_NV_CONFIG;
        end else if (a == NV_DIV_HIGH_ADDR) begin
            return IDX_NV_DIV_HIGH;
        end
        return IDX_NV_DIV_LOW;
    endfunction

    function automatic logic is_nv_target(input logic [15:0] a);
        return in_array(a) || a == NV_CONFIG_ADDR
            || a == NV_DIV_HIGH_ADDR || a == NV_DIV_LOW_ADDR;
    endfunction

    // Checked at latch time and again when the pump is switched on,
    // since the mode bits may change in between
    function automatic logic refused(input logic [9:0] idx,
                                     input eep_mode_e m,
                                     input logic [4:0] cfg,
                                     input logic lock_open);
        logic armed;
        armed = ~cfg[PROTECT_BIT];
        if (idx == IDX_NV_CONFIG) begin
            return armed;
        end
        if (idx == IDX_NV_DIV_HIGH || idx == IDX_NV_DIV_LOW) begin
            return ~lock_open;
        end
        if (cfg[idx[8:7]]) begin
            return 1'b1;
        end
        if (armed && idx[8:0] >= SECURE_LO && idx[8:0] <= SECURE_HI) begin
            return 1'b1;
        end
        if (armed && (m == MODE_BLOCK_ERASE || m == MODE_BULK_ERASE)) begin
            return 1'b1;
        end
        if (m == MODE_BULK_ERASE && |cfg[3:0]) begin
            return 1'b1;
        end
        return 1'b0;
    endfunction

    eep_array u_array (
        .core_clk(core_clk),
        .ce(ce),
        .commit(commit),
        .op(commit_op),
        .rd_idx(req_idx),
        .rd_byte(mem_byte),
        .nv_config_byte(nv_cfg),
        .nv_divider_high(nv_div_high),
        .nv_divider_low(nv_div_low)
    );

    eep_timebase u_timebase (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .crystal_ref_clock(crystal_ref_clock),
        .divider_clock_select(divider_clock_select),
        .divider({div_high & DIV_HIGH_MASK & 8'h07, div_low}),
        .tick(timebase_tick)
    );

    assign req_idx = nv_index(bus_req.addr);
    assign req_mapped = is_nv_target(bus_req.addr);
    assign wr_ctrl = eep_ctrl_s'(bus_req.wdata);

    always_comb begin
        next_ctrl = ctrl;
        next_array_cfg = array_cfg;
        next_div_high = div_high;
        next_div_low = div_low;
        next_load_pending = 1'b0;
        next_latch_valid = latch_valid;
        next_latch_op = latch_op;
        next_state = state;
        next_tick_count = tick_count;
        next_rd_data = 8'h00;
        commit = 1'b0;
        commit_op = latch_op;
        // Block and bulk modes on a register cell erase only that cell
        if (latch_op.idx[9] && latch_op.mode != MODE_PROGRAM) begin
            commit_op.mode = MODE_BYTE_ERASE;
        end

        if (load_pending) begin
            next_array_cfg = nv_cfg[4:0];
            next_div_high = nv_div_high & DIV_HIGH_MASK;
            next_div_low = nv_div_low;
        end else begin
            if (bus_req.wr) begin
                if (bus_req.addr == CONTROL_ADDR) begin
                    next_ctrl.spare = wr_ctrl.spare;
                    next_ctrl.array_power_down = wr_ctrl.array_power_down;
                    next_ctrl.mode = wr_ctrl.mode;
                    next_ctrl.auto_end = wr_ctrl.auto_end;
                    // Latch stays while pump runs so the high voltage
                    // can fall before the buses return to normal
                    next_ctrl.latch_enable_bit = wr_ctrl.latch_enable_bit
                        | ctrl.pump_enable_bit;
                    next_ctrl.pump_enable_bit = wr_ctrl.pump_enable_bit
                        & ctrl.latch_enable_bit & latch_valid
                        & ~wr_ctrl.array_power_down
                        & ~refused(latch_op.idx, wr_ctrl.mode, array_cfg,
                                   div_high[LOCK_BIT]);
                end else if (req_mapped && ctrl.latch_enable_bit
                             && !ctrl.pump_enable_bit) begin
                    if (!refused(req_idx, ctrl.mode, array_cfg,
                                 div_high[LOCK_BIT])) begin
                        next_latch_valid = 1'b1;
                        next_latch_op.idx = req_idx;
                        next_latch_op.data = bus_req.wdata;
                    end
                end else if (bus_req.addr == DIV_HIGH_ADDR
                             && div_high[LOCK_BIT]) begin
                    next_div_high = bus_req.wdata & DIV_HIGH_MASK;
                end else if (bus_req.addr == DIV_LOW_ADDR
                             && div_high[LOCK_BIT]) begin
                    next_div_low = bus_req.wdata;
                end
            end
            if (bus_req.rd) begin
                if (req_mapped) begin
                    if (ctrl.latch_enable_bit && latch_valid) begin
                        next_rd_data = latch_op.data;
                    end else begin
                        next_rd_data = mem_byte;
                    end
                    if (bus_req.addr == NV_CONFIG_ADDR) begin
                        next_array_cfg = nv_cfg[4:0];
                    end
                end else begin
                    unique case (bus_req.addr)
                        CONTROL_ADDR: next_rd_data = ctrl;
                        ARRAY_CFG_ADDR: next_rd_data = {3'b000, array_cfg};
                        DIV_HIGH_ADDR: next_rd_data = div_high;
                        DIV_LOW_ADDR: next_rd_data = div_low;
                        default: next_rd_data = 8'h00;
                    endcase
                end
            end
        end
        next_ctrl.unimpl = 1'b0;
        if (!next_ctrl.latch_enable_bit) begin
            next_latch_valid = 1'b0;
        end

        unique case (state)
            ST_IDLE: begin
                next_tick_count = 8'h00;
                if (next_ctrl.pump_enable_bit) begin
                    next_latch_op.mode = next_ctrl.mode;
                    next_state = ST_PUMP;
                end
            end
            ST_PUMP: begin
                if (timebase_tick) begin
                    next_tick_count = tick_count + 8'h01;
                end
                if (ctrl.auto_end && timebase_tick
                    && tick_count == 8'(OP_TICKS - 1)) begin
                    next_ctrl.pump_enable_bit = 1'b0;
                end
                // Cells change when the pump switches off
                if (!next_ctrl.pump_enable_bit) begin
                    commit = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= eep_ctrl_s'(CONTROL_RESET);
            array_cfg <= 5'h1f;
            div_high <= 8'h00;
            div_low <= 8'h00;
            load_pending <= 1'b1;
            latch_valid <= 1'b0;
            latch_op <= '0;
            state <= ST_IDLE;
            tick_count <= 8'h00;
            rd_data <= 8'h00;
        end else if (ce) begin
            ctrl <= next_ctrl;
            array_cfg <= next_array_cfg;
            div_high <= next_div_high;
            div_low <= next_div_low;
            load_pending <= next_load_pending;
            latch_valid <= next_latch_valid;
            latch_op <= next_latch_op;
            state <= next_state;
            tick_count <= next_tick_count;
            rd_data <= next_rd_data;
        end
    end

    assign pump_on = ctrl.pump_enable_bit;
    assign array_power_down = ctrl.array_power_down;
endmodule // eep_ctrl
`default_nettype wire

// file: eep_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl_chk import eep_pkg::*; #(
    parameter int OP_TICKS = AUTO_TICKS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire eep_bus_req_s bus_req,
    input wire logic [7:0] rd_data,
    input wire logic pump_on,
    input wire logic array_power_down,
    input wire logic timebase_tick
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic ctl_wr;
    logic pump_req;
    logic auto_on;
    logic [7:0] n_tick;
    assign ctl_wr = ce && bus_req.wr && bus_req.addr == CONTROL_ADDR;
    assign pump_req = ctl_wr && bus_req.wdata[0] && !bus_req.wdata[5];
    // Ticks are only bounded while the timer owns the pump bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_on <= 1'b0;
            n_tick <= 8'h00;
        end else begin
            if (ctl_wr) auto_on <= bus_req.wdata[1];
            if (!pump_on) n_tick <= 8'h00;
            else if (timebase_tick && auto_on) n_tick <= n_tick + 8'h01;
        end
    end
    sequence s_cfg_rd;
        ce && bus_req.rd && bus_req.addr == ARRAY_CFG_ADDR;
    endsequence
    property p_rd_idle;
        ce && !bus_req.rd |=> rd_data == 8'h00;
    endproperty
    property p_cfg_top;
        s_cfg_rd |=> rd_data[7:5] == 3'b000;
    endproperty
    property p_cfg_rd2;
        s_cfg_rd ##1 s_cfg_rd |=> rd_data == $past(rd_data);
    endproperty
    property p_div_mask;
        ce && bus_req.rd && bus_req.addr == DIV_HIGH_ADDR
            |=> rd_data[6:3] == 4'h0;
    endproperty
    property p_pump_set;
        $rose(pump_on) |-> $past(pump_req);
    endproperty
    property p_ctrl_pd;
        ctl_wr |=> array_power_down == $past(bus_req.wdata[5]);
    endproperty
    property p_auto_bound;
        n_tick <= OP_TICKS;
    endproperty
    property p_pump_fall;
        $fell(pump_on) |-> $past(ctl_wr) || $past(auto_on);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data lingers");
    a_cfg_top: assert property (p_cfg_top) else $error("config top bits");
    a_cfg_rd2: assert property (p_cfg_rd2) else $error("config unstable");
    a_div_mask: assert property (p_div_mask) else $error("divider mask");
    a_pump_set: assert property (p_pump_set) else $error("pump rose alone");
    a_ctrl_pd: assert property (p_ctrl_pd) else $error("power down bit");
    a_auto_bound: assert property (p_auto_bound) else $error("pump overran");
    a_pump_fall: assert property (p_pump_fall) else $error("pump fell");
endmodule // eep_ctrl_chk
bind eep_ctrl eep_ctrl_chk #(.OP_TICKS(OP_TICKS)) chk_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .pump_on(pump_on),
    .array_power_down(array_power_down),
    .timebase_tick(timebase_tick)
);
`default_nettype wire

// file: eep_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module eep_cpu_model import eep_pkg::*; (
    input wire logic core_clk,
    output var eep_bus_req_s bus_req
);
    initial bus_req = '0;
    task automatic op(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{w, !w, a, d};
    endtask
    // Released lines flip so stale values never look valid
    task automatic done;
        @(posedge core_clk);
        bus_req <= '{1'b0, 1'b0, ~bus_req.addr, ~bus_req.wdata};
    endtask
endmodule // eep_cpu_model
`default_nettype wire

// file: eep_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl_tb import eep_pkg::*; ();
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic sel = 1'b0;
    logic xclk = 1'b0;
    logic [1:0] xph = 2'b00;
    logic rd_pend = 1'b0;
    logic [7:0] rd_data;
    logic pump_on;
    logic pdn;
    logic tick;
    eep_bus_req_s bus_req;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int cmp_count = 0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        xph <= xph + 2'h1;
        xclk <= xph[1];
    end
    eep_ctrl #(.OP_TICKS(2)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .ce(ce), .crystal_ref_clock(xclk), .divider_clock_select(sel),
        .bus_req(bus_req), .rd_data(rd_data), .pump_on(pump_on),
        .array_power_down(pdn), .timebase_tick(tick));
    eep_cpu_model cpu_u (.core_clk(core_clk), .bus_req(bus_req));
    task automatic bad(input string m);
        num_errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        cmp_count++;
        if (got !== e) bad($sformatf("got %h exp %h", got, e));
    endtask
    always @(posedge core_clk) rd_pend <= bus_req.rd;
    always @(negedge core_clk) begin
        if (rd_pend) begin
            cmp_count++;
            if (exp_q.size() == 0) bad("unexpected read");
            else if (rd_data !== exp_q[0]) bad("read data");
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu_u.op(1'b1, a, d);
        cpu_u.done();
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cpu_u.op(1'b0, a, 8'h00);
        cpu_u.done();
    endtask
    task automatic nvop(input logic [15:0] a, input logic [7:0] d,
                        input logic [1:0] m, input logic ok);
        int n;
        n = 0;
        wr(CONTROL_ADDR, {3'b000, m, 3'b110});
        wr(a, d);
        wr(CONTROL_ADDR, {3'b000, m, 3'b111});
        @(negedge core_clk);
        chk(16'(pump_on), 16'(ok));
        while (pump_on === 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        chk(16'(pump_on), 16'h0000);
        wr(CONTROL_ADDR, 8'h00);
    endtask
    // The first gap is partial, only the last one is judged
    task automatic tick_gap(input int e);
        int g;
        g = 0;
        repeat (3) begin
            g = 0;
            do begin
                @(negedge core_clk);
                g++;
            end while (tick !== 1'b1 && g < 100);
        end
        chk(16'(g), 16'(e));
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    initial begin
        #500000;
        bad("watchdog");
        give_verdict();
    end
    initial begin
        logic [7:0] d;
        logic [15:0] a;
        d = 8'($urandom(32'h6bf1));
        do_reset();
        rd(CONTROL_ADDR, CONTROL_RESET);
        rd(ARRAY_CFG_ADDR, 8'h10);
        rd(NV_CONFIG_ADDR, NV_CONFIG_FACTORY);
        rd(DIV_HIGH_ADDR, 8'h87);
        rd(ARRAY_BASE + 16'h01ff, ERASED_BYTE);
        rd(16'hfe1e, 8'h00);
        wr(ARRAY_CFG_ADDR, 8'hef);
        exp_q.push_back(8'h10);
        exp_q.push_back(8'h10);
        cpu_u.op(1'b0, ARRAY_CFG_ADDR, 8'h00);
        cpu_u.op(1'b0, ARRAY_CFG_ADDR, 8'h00);
        cpu_u.done();
        $display("test reset done");
        wr(DIV_HIGH_ADDR, 8'h80);
        wr(DIV_LOW_ADDR, 8'h03);
        rd(DIV_LOW_ADDR, 8'h03);
        // Clock enable low: both writes must be lost
        @(posedge core_clk);
        ce <= 1'b0;
        wr(DIV_LOW_ADDR, 8'h07);
        wr(CONTROL_ADDR, 8'h20);
        ce <= 1'b1;
        @(negedge core_clk);
        chk(16'(pdn), 16'h0000);
        rd(DIV_LOW_ADDR, 8'h03);
        // Spare bit keeps its value, bit 6 always reads zero
        wr(CONTROL_ADDR, 8'he0);
        @(negedge core_clk);
        chk(16'(pdn), 16'h0001);
        rd(CONTROL_ADDR, 8'ha0);
        wr(CONTROL_ADDR, 8'h00);
        tick_gap(3);
        @(posedge core_clk);
        sel <= 1'b1;
        tick_gap(12);
        @(posedge core_clk);
        sel <= 1'b0;
        $display("test timebase done");
        for (int k = 0; k < 4; k++) begin
            nvop(ARRAY_BASE + 16'h0100, ~(8'h01 << k), MODE_PROGRAM, 1'b1);
            rd(ARRAY_BASE + 16'h0100, 8'hff << (k + 1));
        end
        a = ARRAY_BASE + 16'($urandom % 128);
        d = 8'($urandom);
        nvop(a, d, MODE_PROGRAM, 1'b1);
        rd(a, d);
        nvop(a, 8'h00, MODE_BYTE_ERASE, 1'b1);
        rd(a, ERASED_BYTE);
        nvop(ARRAY_BASE + 16'h0180, 8'h00, MODE_PROGRAM, 1'b1);
        nvop(ARRAY_BASE + 16'h0140, 8'h00, MODE_BLOCK_ERASE, 1'b1);
        rd(ARRAY_BASE + 16'h0100, ERASED_BYTE);
        rd(ARRAY_BASE + 16'h0180, 8'h00);
        nvop(ARRAY_BASE, 8'h00, MODE_BULK_ERASE, 1'b1);
        rd(ARRAY_BASE + 16'h0180, ERASED_BYTE);
        // Manual mode: the pump stays on until software clears it
        wr(CONTROL_ADDR, 8'h04);
        wr(ARRAY_BASE + 16'h0020, 8'h5a);
        wr(CONTROL_ADDR, 8'h05);
        repeat (20) @(negedge core_clk);
        chk(16'(pump_on), 16'h0001);
        wr(CONTROL_ADDR, 8'h00);
        rd(CONTROL_ADDR, 8'h04);
        wr(CONTROL_ADDR, 8'h00);
        rd(ARRAY_BASE + 16'h0020, 8'h5a);
        $display("test program erase done");
        nvop(NV_CONFIG_ADDR, 8'h00, MODE_BYTE_ERASE, 1'b1);
        rd(NV_CONFIG_ADDR, 8'hff);
        rd(ARRAY_CFG_ADDR, 8'h1f);
        nvop(ARRAY_BASE + 16'h0080, 8'h00, MODE_PROGRAM, 1'b0);
        rd(ARRAY_BASE + 16'h0080, ERASED_BYTE);
        nvop(NV_CONFIG_ADDR, 8'hf0, MODE_PROGRAM, 1'b1);
        rd(NV_CONFIG_ADDR, 8'hf0);
        rd(ARRAY_CFG_ADDR, 8'h10);
        $display("test block protect done");
        nvop(NV_DIV_LOW_ADDR, 8'h03, MODE_PROGRAM, 1'b1);
        nvop(NV_DIV_HIGH_ADDR, 8'h00, MODE_PROGRAM, 1'b1);
        do_reset();
        rd(DIV_HIGH_ADDR, 8'h00);
        wr(DIV_LOW_ADDR, 8'h09);
        rd(DIV_LOW_ADDR, 8'h03);
        nvop(NV_DIV_LOW_ADDR, 8'h00, MODE_BYTE_ERASE, 1'b0);
        tick_gap(3);
        $display("test divider lock done");
        nvop(NV_CONFIG_ADDR, 8'hef, MODE_PROGRAM, 1'b1);
        do_reset();
        rd(ARRAY_CFG_ADDR, 8'h00);
        nvop(ARRAY_BASE + 16'h00f5, 8'h00, MODE_PROGRAM, 1'b0);
        rd(ARRAY_BASE + 16'h00f5, ERASED_BYTE);
        nvop(ARRAY_BASE + 16'h0010, 8'h0f, MODE_PROGRAM, 1'b1);
        nvop(ARRAY_BASE + 16'h0010, 8'h00, MODE_BLOCK_ERASE, 1'b0);
        nvop(ARRAY_BASE + 16'h0010, 8'h00, MODE_BULK_ERASE, 1'b0);
        rd(ARRAY_BASE + 16'h0010, 8'h0f);
        nvop(NV_CONFIG_ADDR, 8'h00, MODE_BYTE_ERASE, 1'b0);
        rd(NV_CONFIG_ADDR, 8'he0);
        nvop(ARRAY_BASE + 16'h0010, 8'h00, MODE_BYTE_ERASE, 1'b1);
        rd(ARRAY_BASE + 16'h0010, ERASED_BYTE);
        $display("test permanent protect done");
        repeat (2) @(negedge core_clk);
        give_verdict();
    end
endmodule // eep_ctrl_tb
`default_nettype wire
